// *** hw/stfa_fault_aggregator.sv ***
`timescale 1ns/100ps
// How it works
// [RQ1] Any active fault de-energizes the self-test warning relay output.
// [RQ2] Each newly raised fault posts its code to the diagnostic queue.
// [RQ3] Each newly raised fault writes a record to the event recorder port; the record is held back while the diagnostic queue is full.
// [RQ4] Any major fault turns off the in-service lamp.
// [RQ5] Any major fault inhibits all output relays.
// [RQ6] Converter ground check failure is a major fault.
// [RQ7] Uncorrectable data memory corruption is a major fault.
// [RQ8] Program memory CRC error is a major fault.
// [RQ9] Factory service mode is a major fault.
// [RQ10] Loss of the analog output supply is a minor fault.
// [RQ11] Loss of the logic input contact supply is a minor fault.
// [RQ12] Battery lost and battery low are separate minor faults.
// [RQ13] Clock never set is a minor fault.
// [RQ14] Pickup test, forced relays, forced analog outputs are separate minor faults.
// [RQ15] Internal board link failure is a minor fault.
// [RQ16] Temperature below -40 C or above +85 C is a minor fault.
// [RQ17] Time sync enabled yet undecodable is a minor fault.
// [RQ18] Missing factory calibration is a minor fault.
// [RQ19] Prototype software and simulation mode are separate minor faults.
// [RQ20] Operation setting not ready is a minor fault.
// [RQ21] Real-time clock circuit failure is a minor fault.
// [RQ22] Checks run once at power-up, then continuously every cycle.
// [RQ23] With no fault the warning relay is energized and its lamp off.
// [RQ24] Outputs follow the OR of active flags; major effects use major flags only.
module stfa_fault_aggregator (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire stfa_pkg::stfa_monitor_type mon,
  output logic warn_relay_energize,
  output logic warn_lamp,
  output logic in_service_lamp,
  output logic relay_inhibit,
  output stfa_pkg::stfa_event_type event_rec,
  output logic [19:0] fault_vec
);
  import stfa_pkg::*;

  logic [19:0] raw_faults;
  logic [19:0] fault_q;
  logic [19:0] fault_d;
  logic [19:0] new_faults;
  logic [CFG_WIDTH-1:0] cfg_q;
  logic [4:0] q_mem [QDEPTH];
  logic [QPTR_W-1:0] q_wr_q;
  logic [QPTR_W-1:0] q_rd_q;
  logic [QPTR_W:0] q_cnt_q;
  logic [15:0] ev_count_q;
  logic [4:0] new_code;
  logic new_any;
  logic any_fault;
  logic major_fault;
  logic temp_bad;
  logic q_full;
  logic q_empty;
  logic q_push;
  logic q_pop;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_mux;
  stfa_state_type state_q;
  stfa_event_type event_d;

  // Lowest-numbered set bit, used to serialise new faults one per cycle.
  function automatic logic [4:0] lowest_set(input logic [19:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [19:0] onehot(input logic [4:0] code);
    return 20'h00001 << code;
  endfunction

  assign temp_bad = (mon.temp_c < TEMP_MIN_C) || (mon.temp_c > TEMP_MAX_C); // RQ16

  always_comb begin
    raw_faults = 20'h00000;
    raw_faults[F_ADC_GROUND] = mon.adc_ground_fail; // RQ6
    raw_faults[F_DATA_MEM] = mon.data_mem_uncorrectable; // RQ7
    raw_faults[F_PROG_MEM] = mon.prog_mem_crc_error; // RQ8
    raw_faults[F_FACTORY_SERVICE] = mon.factory_service; // RQ9
    raw_faults[F_ANALOG_OUT_SUPPLY] = mon.analog_out_supply_fault; // RQ10
    raw_faults[F_INPUT_SUPPLY] = mon.input_supply_fault; // RQ11
    raw_faults[F_BATTERY_LOST] = mon.battery_lost; // RQ12
    raw_faults[F_BATTERY_LOW] = mon.battery_low; // RQ12
    raw_faults[F_CLOCK_NOT_SET] = mon.clock_never_set; // RQ13
    raw_faults[F_PICKUP_TEST] = cfg_q[CFG_PICKUP]; // RQ14
    raw_faults[F_FORCE_RELAYS] = cfg_q[CFG_FORCE_RELAYS]; // RQ14
    raw_faults[F_FORCE_ANALOG] = cfg_q[CFG_FORCE_ANALOG]; // RQ14
    raw_faults[F_INT_LINK] = mon.int_link_fail; // RQ15
    raw_faults[F_INT_TEMP] = temp_bad; // RQ16
    raw_faults[F_TIME_SYNC] = cfg_q[CFG_SYNC_EN] & mon.time_sync_undecodable; // RQ17
    raw_faults[F_NOT_CALIBRATED] = mon.not_calibrated; // RQ18
    raw_faults[F_PROTO_SW] = mon.proto_software; // RQ19
    raw_faults[F_SIMULATION] = cfg_q[CFG_SIMULATION]; // RQ19
    raw_faults[F_NOT_READY] = ~cfg_q[CFG_READY]; // RQ20
    raw_faults[F_RTC_FAIL] = mon.rtc_fail; // RQ21
  end

  // Flags are recomputed every cycle from the live conditions.
  assign fault_d = raw_faults; // RQ22 RQ24

  // A fault counts as new until it has been reported; one report per cycle.
  logic [19:0] reported_q;
  assign new_faults = fault_q & ~reported_q;
  assign new_any = |new_faults;
  assign new_code = lowest_set(new_faults);

  assign any_fault = |fault_q; // RQ24
  assign major_fault = |(fault_q & MAJOR_MASK); // RQ24

  assign warn_relay_energize = (state_q == ST_RUN) && !any_fault; // RQ1 RQ23
  assign warn_lamp = any_fault; // RQ23
  assign in_service_lamp = (state_q == ST_RUN) && !major_fault; // RQ4
  assign relay_inhibit = (state_q != ST_RUN) || major_fault; // RQ5
  assign fault_vec = fault_q;

  assign q_full = (q_cnt_q == 4'(QDEPTH));
  assign q_empty = (q_cnt_q == 4'h0);
  assign q_push = new_any && !q_full; // RQ2
  assign q_pop = rd_en && (paddr == ADDR_QUEUE) && !q_empty;

  assign event_d.valid = new_any && !q_full; // RQ3
  assign event_d.major = |(onehot(new_code) & MAJOR_MASK);
  assign event_d.code = new_code;

  // The first clocked sample of all checks happens in ST_INIT after reset.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_INIT;
      fault_q <= 20'h00000;
      reported_q <= 20'h00000;
      event_rec <= '0;
    end else begin
      state_q <= ST_RUN; // RQ22
      fault_q <= fault_d;
      reported_q <= (reported_q | (q_push ? onehot(new_code) : 20'h00000)) & fault_d;
      event_rec <= event_d; // RQ3
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_wr_q <= '0;
      q_rd_q <= '0;
      q_cnt_q <= '0;
    end else begin
      if (q_push) begin
        q_wr_q <= q_wr_q + 3'h1;
      end
      if (q_pop) begin
        q_rd_q <= q_rd_q + 3'h1;
      end
      q_cnt_q <= q_cnt_q + 4'(q_push) - 4'(q_pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (q_push) begin
      q_mem[q_wr_q] <= new_code; // RQ2
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_count_q <= 16'h0000;
    end else if (event_d.valid) begin
      ev_count_q <= ev_count_q + 16'h0001;
    end
  end

  // APB slave: zero wait states, error on unmapped address.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == ADDR_STATUS) || (paddr == ADDR_FAULTS) || (paddr == ADDR_CONFIG) ||
                   (paddr == ADDR_QUEUE) || (paddr == ADDR_EVCOUNT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= CFG_RESET;
    end else if (wr_en && (paddr == ADDR_CONFIG)) begin
      cfg_q <= pwdata[CFG_WIDTH-1:0];
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      ADDR_STATUS: rd_mux = {28'h0000000, relay_inhibit, in_service_lamp, major_fault, any_fault};
      ADDR_FAULTS: rd_mux = {12'h000, fault_q};
      ADDR_CONFIG: rd_mux = {26'h0, cfg_q};
      ADDR_QUEUE: rd_mux = q_empty ? QUEUE_EMPTY_WORD :
                           {1'b1, 23'h0, |(onehot(q_mem[q_rd_q]) & MAJOR_MASK), 2'h0, q_mem[q_rd_q]};
      ADDR_EVCOUNT: rd_mux = {16'h0000, ev_count_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign prdata = rd_mux;

  sequence s_link_raised;
    $rose(fault_q[F_INT_LINK]) && (q_cnt_q == 4'h0);
  endsequence

  sequence s_link_logged;
    event_rec.valid && (event_rec.code == F_INT_LINK);
  endsequence

  sequence s_fault_pending;
    new_any && !q_full;
  endsequence

  sequence s_event_posted;
    event_rec.valid && (event_rec.code == $past(new_code));
  endsequence

  a_warn_follows_any: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ1
    (state_q == ST_RUN) |-> (warn_relay_energize == !(|fault_q)))
    else $error("warning relay disagrees with fault flags");

  a_any_warn_lamp: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ1
    (|fault_q) |-> warn_lamp && !warn_relay_energize)
    else $error("fault left warning relay energized");

  a_major_lamp_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ4
    |(fault_q & MAJOR_MASK) |-> !in_service_lamp && relay_inhibit)
    else $error("major fault did not drop lamp and inhibit");

  a_minor_lamp_on: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ4
    (state_q == ST_RUN) && !(|(fault_q & MAJOR_MASK)) |-> in_service_lamp)
    else $error("minor fault dropped in service lamp");

  a_minor_no_inhibit: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ5
    (state_q == ST_RUN) && !(|(fault_q & MAJOR_MASK)) |-> !relay_inhibit)
    else $error("minor fault inhibited relays");

  a_adc_major: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ6
    mon.adc_ground_fail |=> relay_inhibit)
    else $error("converter fault not major");

  a_datamem_major: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ7
    mon.data_mem_uncorrectable |=> !in_service_lamp)
    else $error("data memory fault not major");

  a_prog_crc_major: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ8
    mon.prog_mem_crc_error |=> relay_inhibit && !in_service_lamp)
    else $error("program memory fault not major");

  a_service_major: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ9
    mon.factory_service |=> relay_inhibit && !in_service_lamp)
    else $error("service mode not major");

  a_aout_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ10
    mon.analog_out_supply_fault |=> fault_q[F_ANALOG_OUT_SUPPLY] && !warn_relay_energize)
    else $error("analog output supply loss not flagged");

  a_insup_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ11
    mon.input_supply_fault |=> fault_q[F_INPUT_SUPPLY] && !warn_relay_energize)
    else $error("input contact supply loss not flagged");

  a_batt_lost_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ12
    mon.battery_lost |=> fault_q[F_BATTERY_LOST])
    else $error("battery loss not flagged");

  a_batt_low_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ12
    mon.battery_low && !mon.battery_lost |=> fault_q[F_BATTERY_LOW] && !fault_q[F_BATTERY_LOST])
    else $error("low battery not flagged on its own");

  a_clock_unset: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ13
    mon.clock_never_set |=> fault_q[F_CLOCK_NOT_SET])
    else $error("unset clock not flagged");

  a_pickup_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ14
    cfg_q[CFG_PICKUP] |=> fault_q[F_PICKUP_TEST])
    else $error("pickup test not flagged");

  a_force_rel_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ14
    cfg_q[CFG_FORCE_RELAYS] |=> fault_q[F_FORCE_RELAYS])
    else $error("forced relays not flagged");

  a_force_ana_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ14
    cfg_q[CFG_FORCE_ANALOG] |=> fault_q[F_FORCE_ANALOG])
    else $error("forced analog outputs not flagged");

  a_link_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ15
    mon.int_link_fail |=> fault_q[F_INT_LINK] && !warn_relay_energize)
    else $error("board link failure not flagged");

  a_temp_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ16
    (mon.temp_c > TEMP_MAX_C) |=> fault_q[F_INT_TEMP] && !warn_relay_energize)
    else $error("over temperature not flagged");

  a_cold_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ16
    (mon.temp_c < TEMP_MIN_C) |=> fault_q[F_INT_TEMP])
    else $error("under temperature not flagged");

  a_temp_inband: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ16
    (mon.temp_c >= TEMP_MIN_C) && (mon.temp_c <= TEMP_MAX_C) |=> !fault_q[F_INT_TEMP])
    else $error("temperature in band flagged");

  a_sync_gated: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ17
    !cfg_q[CFG_SYNC_EN] |=> !fault_q[F_TIME_SYNC])
    else $error("sync fault raised while disabled");

  a_sync_raised: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ17
    cfg_q[CFG_SYNC_EN] && mon.time_sync_undecodable |=> fault_q[F_TIME_SYNC])
    else $error("undecodable sync not flagged");

  a_uncal_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ18
    mon.not_calibrated |=> fault_q[F_NOT_CALIBRATED])
    else $error("missing calibration not flagged");

  a_proto_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ19
    mon.proto_software |=> fault_q[F_PROTO_SW])
    else $error("prototype software not flagged");

  a_sim_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ19
    cfg_q[CFG_SIMULATION] |=> fault_q[F_SIMULATION])
    else $error("simulation mode not flagged");

  a_not_ready: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ20
    !sys_rst && !cfg_q[CFG_READY] |=> fault_q[F_NOT_READY])
    else $error("operation not ready not flagged");

  a_rtc_minor: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ21
    mon.rtc_fail |=> fault_q[F_RTC_FAIL])
    else $error("clock circuit failure not flagged");

  a_new_fault_logged: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ3
    s_link_raised |-> ##[1:20] s_link_logged)
    else $error("new fault never logged");

  a_event_posted: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ3
    s_fault_pending |=> s_event_posted)
    else $error("pending fault not recorded");

  a_queue_push: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ2
    q_push && !q_pop |=> q_cnt_q == $past(q_cnt_q) + 4'h1)
    else $error("queue did not take new fault");

  a_queue_bound: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ2
    q_cnt_q <= 4'(QDEPTH))
    else $error("queue count beyond depth");

  a_idle_outputs: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ23
    (state_q == ST_RUN) && (fault_q == 20'h00000) |-> warn_relay_energize && !warn_lamp)
    else $error("idle warning outputs wrong");

  a_init_then_run: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ22
    !sys_rst && (state_q == ST_INIT) |=> (state_q == ST_RUN))
    else $error("checks did not go continuous");

endmodule // stfa_fault_aggregator

// *** hw/stfa_pkg.sv ***
package stfa_pkg;

  // Fault codes, one bit position each in the fault vector.
  localparam int unsigned NUM_FAULTS = 20;
  localparam logic [4:0] F_ADC_GROUND = 5'h00;
  localparam logic [4:0] F_ANALOG_OUT_SUPPLY = 5'h01;
  localparam logic [4:0] F_BATTERY_LOST = 5'h02;
  localparam logic [4:0] F_CLOCK_NOT_SET = 5'h03;
  localparam logic [4:0] F_INPUT_SUPPLY = 5'h04;
  localparam logic [4:0] F_DATA_MEM = 5'h05;
  localparam logic [4:0] F_FACTORY_SERVICE = 5'h06;
  localparam logic [4:0] F_PROG_MEM = 5'h07;
  localparam logic [4:0] F_FORCE_ANALOG = 5'h08;
  localparam logic [4:0] F_FORCE_RELAYS = 5'h09;
  localparam logic [4:0] F_INT_LINK = 5'h0A;
  localparam logic [4:0] F_INT_TEMP = 5'h0B;
  localparam logic [4:0] F_TIME_SYNC = 5'h0C;
  localparam logic [4:0] F_BATTERY_LOW = 5'h0D;
  localparam logic [4:0] F_NOT_CALIBRATED = 5'h0E;
  localparam logic [4:0] F_PICKUP_TEST = 5'h0F;
  localparam logic [4:0] F_PROTO_SW = 5'h10;
  localparam logic [4:0] F_NOT_READY = 5'h11;
  localparam logic [4:0] F_RTC_FAIL = 5'h12;
  localparam logic [4:0] F_SIMULATION = 5'h13;

  // Bits set here are major faults; all others are minor.
  localparam logic [19:0] MAJOR_MASK = 20'h000E1;

  // Temperature limits in whole degrees C, signed.
  localparam logic signed [9:0] TEMP_MIN_C = -10'sd40;
  localparam logic signed [9:0] TEMP_MAX_C = 10'sd85;

  // APB register byte addresses.
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_FAULTS = 12'h004;
  localparam logic [11:0] ADDR_CONFIG = 12'h008;
  localparam logic [11:0] ADDR_QUEUE = 12'h00C;
  localparam logic [11:0] ADDR_EVCOUNT = 12'h010;

  // Config register fields and reset value.
  localparam int unsigned CFG_SYNC_EN = 0;
  localparam int unsigned CFG_PICKUP = 1;
  localparam int unsigned CFG_FORCE_RELAYS = 2;
  localparam int unsigned CFG_FORCE_ANALOG = 3;
  localparam int unsigned CFG_SIMULATION = 4;
  localparam int unsigned CFG_READY = 5;
  localparam int unsigned CFG_WIDTH = 6;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // Diagnostic queue depth and queue read word fields.
  localparam int unsigned QDEPTH = 8;
  localparam int unsigned QPTR_W = 3;
  localparam logic [31:0] QUEUE_EMPTY_WORD = 32'h00000000;
  localparam int unsigned QW_VALID = 31;

  typedef struct packed {
    logic adc_ground_fail;
    logic analog_out_supply_fault;
    logic battery_lost;
    logic battery_low;
    logic clock_never_set;
    logic input_supply_fault;
    logic data_mem_uncorrectable;
    logic factory_service;
    logic prog_mem_crc_error;
    logic int_link_fail;
    logic signed [9:0] temp_c;
    logic time_sync_undecodable;
    logic not_calibrated;
    logic proto_software;
    logic rtc_fail;
  } stfa_monitor_type;

  typedef struct packed {
    logic valid;
    logic major;
    logic [4:0] code;
  } stfa_event_type;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01
  } stfa_state_type;

endpackage

// *** sim/stfa_fault_aggregator_bench.sv ***
`timescale 1ns/100ps
module stfa_fault_aggregator_bench;
  import stfa_pkg::*;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] fault_vec;
  logic warn_relay_energize, warn_lamp, in_service_lamp, relay_inhibit;
  stfa_monitor_type mon;
  stfa_event_type event_rec;
  int mismatches, n_checks, ev_exp;
  // Fault codes and major flags of the scenario table, index i.
  logic [4:0] code_t [20] = '{F_ADC_GROUND, F_ANALOG_OUT_SUPPLY, F_BATTERY_LOST, F_BATTERY_LOW,
    F_CLOCK_NOT_SET, F_INPUT_SUPPLY, F_DATA_MEM, F_FACTORY_SERVICE, F_PROG_MEM, F_INT_LINK,
    F_NOT_CALIBRATED, F_PROTO_SW, F_RTC_FAIL, F_INT_TEMP, F_INT_TEMP, F_TIME_SYNC,
    F_PICKUP_TEST, F_FORCE_RELAYS, F_FORCE_ANALOG, F_SIMULATION};
  logic [19:0] maj_t = 20'h001C1;

  stfa_fault_aggregator u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mon(mon), .warn_relay_energize(warn_relay_energize), .warn_lamp(warn_lamp),
    .in_service_lamp(in_service_lamp), .relay_inhibit(relay_inhibit), .event_rec(event_rec),
    .fault_vec(fault_vec));

  function automatic stfa_monitor_type mk(int i);
    stfa_monitor_type m;
    m = '0;
    m.temp_c = 10'sd25;
    case (i)
      0: m.adc_ground_fail = 1'b1;
      1: m.analog_out_supply_fault = 1'b1;
      2: m.battery_lost = 1'b1;
      3: m.battery_low = 1'b1;
      4: m.clock_never_set = 1'b1;
      5: m.input_supply_fault = 1'b1;
      6: m.data_mem_uncorrectable = 1'b1;
      7: m.factory_service = 1'b1;
      8: m.prog_mem_crc_error = 1'b1;
      9: m.int_link_fail = 1'b1;
      10: m.not_calibrated = 1'b1;
      11: m.proto_software = 1'b1;
      12: m.rtc_fail = 1'b1;
      13: m.temp_c = -10'sd41;
      14: m.temp_c = 10'sd86;
      15: m.time_sync_undecodable = 1'b1;
      20: m.temp_c = TEMP_MIN_C;
      21: m.temp_c = TEMP_MAX_C;
      default: ;
    endcase
    return m;
  endfunction

  // Settings word: operation ready, plus one test setting for the last five entries.
  function automatic logic [31:0] cfgof(int i);
    logic [31:0] c;
    c = 32'h00000001 << CFG_READY;
    if (i >= 15 && i < 20) begin
      c = c | (32'h00000001 << (i - 15));
    end
    return c;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ev(input logic [4:0] c, input logic m);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (event_rec.valid !== 1'b1 && n < 8);
    ev_exp++;
    chk("event", event_rec, {1'b1, m, c});
    chk("fault_vec", fault_vec[c], 1'b1);
    chk("warn_relay", warn_relay_energize, 1'b0);
    chk("warn_lamp", warn_lamp, 1'b1);
    chk("in_service", in_service_lamp, !m);
    chk("inhibit", relay_inhibit, m);
  endtask

  task automatic sw_check(input logic [4:0] c, input logic m);
    apb(1'b0, ADDR_QUEUE, 32'h0);
    chk("queue", rd, {1'b1, 23'h0, m, 2'b00, c});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, {28'h0, m, !m, m, 1'b1});
  endtask

  task automatic clear;
    @(posedge sys_clk);
    mon <= mk(99);
    apb(1'b1, ADDR_CONFIG, cfgof(99));
    @(posedge sys_clk);
    #1;
    chk("fault_vec clear", fault_vec, 20'h0);
    chk("idle outputs", {warn_relay_energize, warn_lamp, in_service_lamp, relay_inhibit}, 4'hA);
  endtask

  task automatic t_reset;
    repeat (3) @(posedge sys_clk);
    chk("reset outputs", {warn_relay_energize, in_service_lamp, relay_inhibit, event_rec.valid}, 4'h2);
    sys_rst <= 1'b0;
    wait_ev(F_NOT_READY, 1'b0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config reset", rd, {26'h0, CFG_RESET});
    sw_check(F_NOT_READY, 1'b0);
    clear;
    $display("test reset done");
  endtask

  task automatic t_each;
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, ADDR_CONFIG, cfgof(i));
      @(posedge sys_clk);
      mon <= mk(i);
      wait_ev(code_t[i], maj_t[i]);
      sw_check(code_t[i], maj_t[i]);
      clear;
    end
    $display("test each fault done");
  endtask

  task automatic t_quiet;
    for (int j = 20; j < 23; j++) begin
      @(posedge sys_clk);
      mon <= mk(j == 22 ? 15 : j);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("no fault", fault_vec, 20'h0);
    end
    clear;
    $display("test boundaries done");
  endtask

  task automatic t_two_and_bus;
    stfa_monitor_type m;
    m = mk(0);
    m.int_link_fail = 1'b1;
    @(posedge sys_clk);
    mon <= m;
    wait_ev(F_ADC_GROUND, 1'b1);
    @(posedge sys_clk);
    #1;
    ev_exp++;
    chk("second event", event_rec, {2'b10, F_INT_LINK});
    chk("inhibit held", relay_inhibit, 1'b1);
    sw_check(F_ADC_GROUND, 1'b1);
    apb(1'b0, ADDR_QUEUE, 32'h0);
    chk("queue second", rd, {1'b1, 26'h0, F_INT_LINK});
    clear;
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", perr, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status ro", rd, 32'h00000004);
    apb(1'b0, ADDR_EVCOUNT, 32'h0);
    chk("evcount", rd[15:0], ev_exp[15:0]);
    $display("test two faults and bus done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    mismatches++;
    wrap_up;
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mon = mk(99);
    t_reset;
    t_each;
    t_quiet;
    t_two_and_bus;
    wrap_up;
  end
endmodule // stfa_fault_aggregator_bench
